// ---- sfdr_top.v ----
`timescale 1ns/10ps
`include "sfdr_regs.vh"
module sfdr_top (
  input wire sys_clk, // 25 MHz clock
  input wire rst, // sync reset, active high
  input wire cmd_wr, // command write strobe
  input wire cmd_rd, // command read strobe
  input wire [7:0] cmd_code, // command code
  input wire [15:0] cmd_wdata, // write data
  output reg [15:0] cmd_rdata_q, // read data
  output reg cmd_ack_q, // command done pulse
  output reg cmd_err_q, // command refused pulse
  input wire adc_valid, // new conversion
  input wire [4:0] adc_chan, // converted channel
  input wire [11:0] adc_code, // conversion result
  input wire adc_ovr, // input beyond selected range
  output reg [16:0] seq_fault_ov_q, // overvoltage faults to sequencer
  output reg [16:0] seq_fault_uv_q, // undervoltage faults to sequencer
  output reg [16:0] logic_warn_ov_q, // overvoltage warnings to logic block
  output reg [16:0] logic_warn_uv_q, // undervoltage warnings to logic block
  input wire nv_check_valid, // power-up check results ready
  input wire nv_boot_ok, // boot loader good
  input wire nv_fw_ok, // firmware good
  input wire nv_main_ok, // main configuration good
  input wire nv_backup_ok, // backup configuration good
  output reg cascade_report_valid_q, // report pulse to cascade master
  output reg [3:0] cascade_report_q, // boot, fw, main, backup results
  input wire cascade_sel_valid, // master selection pulse
  input wire cascade_sel_backup, // master picks backup configuration
  output reg cfg_ready_q, // configuration chosen, supervision running
  output reg cfg_use_backup_q // backup configuration in use
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function signed [39:0] lin_eff;
    input signed [17:0] mant;
    input [4:0] ex;
    reg signed [39:0] w;
    begin
      w = {{22{mant[17]}}, mant};
      if (ex[4])
        lin_eff = w >>> (5'h00 - ex);
      else
        lin_eff = w <<< ex[3:0];
    end
  endfunction

  function signed [17:0] sx;
    input [15:0] v;
    begin
      sx = {{2{v[15]}}, v};
    end
  endfunction

  // out-of-range channel codes fold onto channel 0 for lookups
  function [4:0] chan_idx;
    input [4:0] ch;
    begin
      chan_idx = (ch <= `SFDR_LAST_CH) ? ch : 5'h00;
    end
  endfunction

  // range legal for the channel type
  function range_ok;
    input [4:0] ch;
    input [2:0] rng;
    begin
      if (ch < `SFDR_FIRST_LOW)
        range_ok = (rng != `SFDR_RNG_LOW_ONLY) && (rng <= `SFDR_RNG_HI_B);
      else
        range_ok = (rng <= `SFDR_RNG_LOW_ONLY);
    end
  endfunction

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  reg [4:0] page_q;
  reg [7:0] exp_q;
  reg [15:0] trim_q [0:16];
  reg [15:0] scale_q [0:16];
  reg [15:0] ovf_q [0:16];
  reg [15:0] ovw_q [0:16];
  reg [15:0] uvw_q [0:16];
  reg [15:0] uvf_q [0:16];
  reg [15:0] ovh_q [0:16];
  reg [15:0] uvh_q [0:16];
  reg [15:0] cfg_q [0:16];
  reg [15:0] raw_q [0:16];
  reg [15:0] rdg_q [0:16];
  reg [16:0] ovr_q;
  reg samp_q;
  reg [4:0] samp_ch_q;
  integer i, j, k;

  wire [15:0] wcfg = cmd_wdata;
  wire [6:0] wflt_in = wcfg[`SFDR_CFG_FLT_HI:`SFDR_CFG_FLT_LO];
  wire [6:0] wflt = (wflt_in < `SFDR_FLT_MIN_US) ? `SFDR_FLT_MIN_US :
                    (wflt_in > `SFDR_FLT_MAX_US) ? `SFDR_FLT_MAX_US : wflt_in;
  wire [15:0] cfg_clamped = {wcfg[15:12], wflt, wcfg[4:0]};
  wire cfg_legal = range_ok(page_q, wcfg[`SFDR_CFG_RNG_HI:`SFDR_CFG_RNG_LO]);

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      page_q <= 5'h00;
      exp_q <= `SFDR_RST_EXP;
      cmd_ack_q <= 1'b0;
      cmd_err_q <= 1'b0;
      for (i = 0; i < `SFDR_NCH; i = i + 1)
      begin
        trim_q[i] <= `SFDR_RST_WORD;
        scale_q[i] <= `SFDR_RST_SCALE;
        ovf_q[i] <= `SFDR_RST_WORD;
        ovw_q[i] <= `SFDR_RST_WORD;
        uvw_q[i] <= `SFDR_RST_WORD;
        uvf_q[i] <= `SFDR_RST_WORD;
        ovh_q[i] <= `SFDR_RST_WORD;
        uvh_q[i] <= `SFDR_RST_WORD;
        cfg_q[i] <= `SFDR_RST_WORD;
      end
    end
    else
    begin
      cmd_ack_q <= cmd_wr | cmd_rd;
      cmd_err_q <= 1'b0;
      if (cmd_wr)
      begin
        case (cmd_code)
          `SFDR_CMD_PAGE:
          begin
            if (cmd_wdata[4:0] <= `SFDR_LAST_CH && cmd_wdata[15:5] == 11'h000)
              page_q <= cmd_wdata[4:0];
            else
              cmd_err_q <= 1'b1;
          end
          `SFDR_CMD_EXP: exp_q <= cmd_wdata[7:0];
          `SFDR_CMD_TRIM: trim_q[page_q] <= cmd_wdata;
          `SFDR_CMD_SCALE: scale_q[page_q] <= cmd_wdata;
          `SFDR_CMD_OVF: ovf_q[page_q] <= cmd_wdata;
          `SFDR_CMD_UVF: uvf_q[page_q] <= cmd_wdata;
          `SFDR_CMD_OVW: ovw_q[page_q] <= cmd_wdata;
          `SFDR_CMD_UVW: uvw_q[page_q] <= cmd_wdata;
          `SFDR_CMD_OVH: ovh_q[page_q] <= cmd_wdata;
          `SFDR_CMD_UVH: uvh_q[page_q] <= cmd_wdata;
          `SFDR_CMD_CFG:
          begin
            // an illegal range keeps the old setting
            if (cfg_legal)
              cfg_q[page_q] <= cfg_clamped;
            else
              cmd_err_q <= 1'b1;
          end
          default: cmd_err_q <= 1'b1;
        endcase
      end
      else if (cmd_rd)
      begin
        case (cmd_code)
          `SFDR_CMD_PAGE, `SFDR_CMD_EXP, `SFDR_CMD_TRIM, `SFDR_CMD_SCALE,
          `SFDR_CMD_OVF, `SFDR_CMD_UVF, `SFDR_CMD_OVW, `SFDR_CMD_UVW,
          `SFDR_CMD_OVH, `SFDR_CMD_UVH, `SFDR_CMD_CFG, `SFDR_CMD_READ,
          `SFDR_CMD_STAT: cmd_err_q <= 1'b0;
          default: cmd_err_q <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
      cmd_rdata_q <= 16'h0000;
    else if (cmd_rd)
    begin
      case (cmd_code)
        `SFDR_CMD_PAGE: cmd_rdata_q <= {11'h000, page_q};
        `SFDR_CMD_EXP: cmd_rdata_q <= {8'h00, exp_q};
        `SFDR_CMD_TRIM: cmd_rdata_q <= trim_q[page_q];
        `SFDR_CMD_SCALE: cmd_rdata_q <= scale_q[page_q];
        `SFDR_CMD_OVF: cmd_rdata_q <= ovf_q[page_q];
        `SFDR_CMD_UVF: cmd_rdata_q <= uvf_q[page_q];
        `SFDR_CMD_OVW: cmd_rdata_q <= ovw_q[page_q];
        `SFDR_CMD_UVW: cmd_rdata_q <= uvw_q[page_q];
        `SFDR_CMD_OVH: cmd_rdata_q <= ovh_q[page_q];
        `SFDR_CMD_UVH: cmd_rdata_q <= uvh_q[page_q];
        `SFDR_CMD_CFG: cmd_rdata_q <= cfg_q[page_q];
        `SFDR_CMD_READ: cmd_rdata_q <= rdg_q[page_q];
        `SFDR_CMD_STAT: cmd_rdata_q <= {9'h000, cfg_use_backup_q, cfg_ready_q, ovr_q[page_q],
                                        logic_warn_uv_q[page_q], logic_warn_ov_q[page_q],
                                        seq_fault_uv_q[page_q], seq_fault_ov_q[page_q]};
        default: cmd_rdata_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // ADC capture and readback
  // ----------------------------------------
  // divider ratio is a 4.12 fixed-point gain on the raw code
  wire [27:0] scaled = adc_code * scale_q[chan_idx(adc_chan)];
  wire [15:0] sensed = scaled[27:12];
  wire signed [17:0] rb_sum = {2'b00, sensed} +
                              sx(trim_q[chan_idx(adc_chan)]);
  // readback saturates rather than wrap
  wire [15:0] rb_sat = rb_sum[17] ? 16'h0000 : (rb_sum[16] ? 16'hFFFF : rb_sum[15:0]);

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ovr_q <= 17'h00000;
      samp_q <= 1'b0;
      samp_ch_q <= 5'h00;
      for (j = 0; j < `SFDR_NCH; j = j + 1)
      begin
        raw_q[j] <= `SFDR_RST_WORD;
        rdg_q[j] <= `SFDR_RST_WORD;
      end
    end
    else
    begin
      samp_q <= adc_valid && (adc_chan <= `SFDR_LAST_CH);
      samp_ch_q <= adc_chan;
      if (adc_valid && adc_chan <= `SFDR_LAST_CH)
      begin
        raw_q[adc_chan] <= sensed;
        rdg_q[adc_chan] <= rb_sat;
        ovr_q[adc_chan] <= adc_ovr;
      end
    end
  end

  // ----------------------------------------
  // per-channel comparators
  // ----------------------------------------
  wire signed [39:0] val_eff [0:16];
  wire [16:0] fault_w;
  wire [4:0] ex = exp_q[4:0];

  genvar c;
  generate
    for (c = 0; c < `SFDR_NCH; c = c + 1)
    begin : g_ch
      wire [15:0] cf = cfg_q[c];
      wire signed [17:0] own = {2'b00, raw_q[c]};
      wire signed [17:0] diff_val;
      if (c >= `SFDR_FIRST_LOW && c < `SFDR_NCH - 1 && ((c - `SFDR_FIRST_LOW) % 2) == 0)
      begin : g_pair
        // pair partner reading is subtracted only in differential mode
        assign diff_val = cf[`SFDR_CFG_DIFF] ? own - {2'b00, raw_q[c + 1]} : own;
      end
      else
      begin : g_single
        assign diff_val = own;
      end
      assign val_eff[c] = ovr_q[c] ? 40'sh7FFFFFFFFF : lin_eff(diff_val, ex);
      wire signed [17:0] thr = (cf[`SFDR_CFG_OV] ? sx(ovf_q[c]) : sx(uvf_q[c])) + sx(trim_q[c]);
      wire signed [17:0] clr = cf[`SFDR_CFG_OV] ? thr - sx(ovh_q[c]) : thr + sx(uvh_q[c]);
      wire [11:0] flt = {5'h00, cf[`SFDR_CFG_FLT_HI:`SFDR_CFG_FLT_LO]} * `SFDR_CLK_MHZ;
      sfdr_chan u_chan (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(cf[`SFDR_CFG_EN] & cfg_ready_q),
        .mode_ov(cf[`SFDR_CFG_OV]),
        .value(val_eff[c]),
        .set_lim(lin_eff(thr, ex)),
        .clr_lim(lin_eff(clr, ex)),
        .filt_cycles(flt),
        .fault_q(fault_w[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // faults to sequencer, warnings to logic block
  // ----------------------------------------
  reg [16:0] mode_ov_v;
  always @*
  begin
    for (k = 0; k < `SFDR_NCH; k = k + 1)
      mode_ov_v[k] = cfg_q[k][`SFDR_CFG_OV];
  end

  wire [15:0] scf = cfg_q[samp_ch_q];
  wire signed [39:0] w_ov_lim = lin_eff(sx(ovw_q[samp_ch_q]) + sx(trim_q[samp_ch_q]), ex);
  wire signed [39:0] w_uv_lim = lin_eff(sx(uvw_q[samp_ch_q]) + sx(trim_q[samp_ch_q]), ex);
  wire signed [39:0] w_val = val_eff[samp_ch_q];

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      seq_fault_ov_q <= 17'h00000;
      seq_fault_uv_q <= 17'h00000;
      logic_warn_ov_q <= 17'h00000;
      logic_warn_uv_q <= 17'h00000;
    end
    else
    begin
      seq_fault_ov_q <= fault_w & mode_ov_v;
      seq_fault_uv_q <= fault_w & ~mode_ov_v;
      // warnings only refresh when that channel is converted again
      if (samp_q)
      begin
        logic_warn_ov_q[samp_ch_q] <= scf[`SFDR_CFG_EN] & cfg_ready_q & (w_val > w_ov_lim);
        logic_warn_uv_q[samp_ch_q] <= scf[`SFDR_CFG_EN] & cfg_ready_q & (w_val < w_uv_lim);
      end
    end
  end

  // ----------------------------------------
  // power-up integrity and cascade selection
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      cascade_report_valid_q <= 1'b0;
      cascade_report_q <= 4'h0;
      cfg_ready_q <= 1'b0;
      cfg_use_backup_q <= 1'b0;
    end
    else
    begin
      cascade_report_valid_q <= nv_check_valid;
      if (nv_check_valid)
        cascade_report_q <= {nv_boot_ok, nv_fw_ok, nv_main_ok, nv_backup_ok};
      // selection only taken once, until the next reset
      if (cascade_sel_valid && !cfg_ready_q)
      begin
        cfg_ready_q <= 1'b1;
        cfg_use_backup_q <= cascade_sel_backup;
      end
    end
  end
endmodule

// ---- sfdr_regs.vh ----
`ifndef SFDR_REGS_VH
`define SFDR_REGS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define SFDR_CMD_PAGE     8'h00
`define SFDR_CMD_EXP      8'h20
`define SFDR_CMD_TRIM     8'h22
`define SFDR_CMD_SCALE    8'h2A
`define SFDR_CMD_OVF      8'h40
`define SFDR_CMD_OVW      8'h42
`define SFDR_CMD_UVW      8'h43
`define SFDR_CMD_UVF      8'h44
`define SFDR_CMD_READ     8'h8B
`define SFDR_CMD_OVH      8'hD0
`define SFDR_CMD_UVH      8'hD1
`define SFDR_CMD_CFG      8'hD2
`define SFDR_CMD_STAT     8'hD3
// ----------------------------------------
// channel layout
// ----------------------------------------
`define SFDR_NCH          17
`define SFDR_LAST_CH      5'h10
`define SFDR_FIRST_LOW    4
// ----------------------------------------
// channel config fields
// ----------------------------------------
`define SFDR_CFG_OV       0
`define SFDR_CFG_RNG_LO   1
`define SFDR_CFG_RNG_HI   3
`define SFDR_CFG_DIFF     4
`define SFDR_CFG_FLT_LO   5
`define SFDR_CFG_FLT_HI   11
`define SFDR_CFG_EN       15
`define SFDR_RNG_LOW_ONLY 3'h3
`define SFDR_RNG_HI_A     3'h4
`define SFDR_RNG_HI_B     3'h5
// ----------------------------------------
// reset values
// ----------------------------------------
`define SFDR_RST_EXP      8'h00
`define SFDR_RST_WORD     16'h0000
`define SFDR_RST_SCALE    16'h1000
// ----------------------------------------
// timing
// ----------------------------------------
`define SFDR_CLK_MHZ      12'h019
`define SFDR_FLT_MIN_US   7'h02
`define SFDR_FLT_MAX_US   7'h64
`define SFDR_SCAN_MS      5
`define SFDR_SCALE_SHIFT  12
`endif

// ---- sfdr_chan.v ----
`timescale 1ns/10ps
`include "sfdr_regs.vh"
module sfdr_chan (
  input wire sys_clk, // system clock
  input wire rst, // sync reset, active high
  input wire enable, // channel supervises
  input wire mode_ov, // 1 overvoltage, 0 undervoltage
  input wire signed [39:0] value, // effective sensed value
  input wire signed [39:0] set_lim, // effective threshold
  input wire signed [39:0] clr_lim, // threshold moved by hysteresis
  input wire [11:0] filt_cycles, // glitch filter length
  output reg fault_q // filtered fault
);
  reg [11:0] cnt_q;
  wire beyond_set = mode_ov ? (value > set_lim) : (value < set_lim);
  wire back_in = mode_ov ? (value < clr_lim) : (value > clr_lim);

  // ----------------------------------------
  // filter and hysteresis, every clock
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst || !enable)
    begin
      fault_q <= 1'b0;
      cnt_q <= 12'h000;
    end
    else if (!fault_q)
    begin
      if (!beyond_set)
        cnt_q <= 12'h000;
      else if (cnt_q >= filt_cycles)
      begin
        fault_q <= 1'b1;
        cnt_q <= 12'h000;
      end
      else
        cnt_q <= cnt_q + 12'h001;
    end
    else if (back_in)
      fault_q <= 1'b0;
  end
endmodule

// ---- sfdr_top_properties.sv ----
`timescale 1ns/10ps
module sfdr_props (
  input wire sys_clk, // clock
  input wire rst, // sync reset
  input wire cmd_wr, // write strobe
  input wire cmd_rd, // read strobe
  input wire [7:0] cmd_code, // command
  input wire cmd_ack_q, // done pulse
  input wire cmd_err_q, // refused pulse
  input wire adc_valid, // conversion
  input wire [16:0] seq_fault_ov_q, // ov faults
  input wire [16:0] seq_fault_uv_q, // uv faults
  input wire [16:0] logic_warn_ov_q, // ov warnings
  input wire [16:0] logic_warn_uv_q, // uv warnings
  input wire nv_check_valid, // checks ready
  input wire nv_boot_ok, // boot good
  input wire nv_fw_ok, // firmware good
  input wire nv_main_ok, // main good
  input wire nv_backup_ok, // backup good
  input wire cascade_report_valid_q, // report pulse
  input wire [3:0] cascade_report_q, // report
  input wire cascade_sel_valid, // selection
  input wire cascade_sel_backup, // pick backup
  input wire cfg_ready_q, // running
  input wire cfg_use_backup_q // backup in use
);
  // ----------------------------------------
  // supervision age, saturating
  // ----------------------------------------
  reg [6:0] run_q;
  wire [6:0] run_d;
  assign run_d = !cfg_ready_q ? 7'h00 : (&run_q ? run_q : run_q + 7'h01);
  always @(posedge sys_clk)
  begin
    if (rst)
      run_q <= 7'h00;
    else
      run_q <= run_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_limit_wr;
    cmd_wr && (cmd_code inside {8'h20, 8'h22, 8'h2A, 8'h40, 8'h42, 8'h43, 8'h44, 8'hD0, 8'hD1});
  endsequence
  sequence s_first_pick;
    !cfg_ready_q && cascade_sel_valid;
  endsequence
  ack_one_cycle_a: assert property ((cmd_wr || cmd_rd) |=> cmd_ack_q ##1 (!cmd_ack_q || $past(cmd_wr || cmd_rd)))
    else $error("ack not a single pulse after strobe");
  limit_write_ok_a: assert property (
    s_limit_wr |=> cmd_ack_q && !cmd_err_q)
    else $error("limit write refused");
  readback_ro_a: assert property (cmd_wr && cmd_code == 8'h8B |=> cmd_err_q)
    else $error("write to readback accepted");
  warn_from_adc_a: assert property (
    $changed(logic_warn_ov_q | logic_warn_uv_q) |-> $past(adc_valid, 2) || $past(cmd_wr) || $past(cmd_wr, 2))
    else $error("warning moved without a reading");
  fault_filtered_a: assert property (
    (|(seq_fault_ov_q & ~$past(seq_fault_ov_q))) || (|(seq_fault_uv_q & ~$past(seq_fault_uv_q))) |-> run_q > 7'h28)
    else $error("fault faster than filter");
  idle_until_ready_a: assert property (!cfg_ready_q |-> !(|seq_fault_ov_q) && !(|seq_fault_uv_q))
    else $error("fault before configuration chosen");
  report_follows_check_a: assert property (
    nv_check_valid |=> cascade_report_valid_q &&
      cascade_report_q == $past({nv_boot_ok, nv_fw_ok, nv_main_ok, nv_backup_ok}))
    else $error("check report wrong");
  report_needs_check_a: assert property (cascade_report_valid_q |-> $past(nv_check_valid))
    else $error("report without check");
  select_applied_a: assert property (
    s_first_pick |=> cfg_ready_q && cfg_use_backup_q == $past(cascade_sel_backup))
    else $error("selection not applied");
  select_sticky_a: assert property (cfg_ready_q |=> cfg_ready_q && $stable(cfg_use_backup_q))
    else $error("selection changed");
endmodule
bind sfdr_top sfdr_props chk_u (.*);

// ---- sfdr_rail_model.sv ----
`timescale 1ns/10ps
module sfdr_rail_model (
  input wire sys_clk, // system clock
  input wire rst, // no scan during reset
  input wire [203:0] rails, // rail codes, 12 bits each
  input wire [16:0] over, // rails beyond range
  input wire cascade_report_valid_q, // check report pulse
  input wire [3:0] cascade_report_q, // boot, fw, main, backup
  output reg adc_valid, // conversion pulse
  output reg [4:0] adc_chan, // converted channel
  output reg [11:0] adc_code, // result
  output reg adc_ovr, // beyond range
  output reg cascade_sel_valid, // master selection
  output reg cascade_sel_backup // master picks backup
);
  reg [4:0] ch_q;
  initial
  begin
    adc_valid = 1'b0;
    adc_chan = 5'h00;
    adc_code = 12'h000;
    adc_ovr = 1'b0;
    cascade_sel_valid = 1'b0;
    cascade_sel_backup = 1'b0;
    ch_q = 5'h00;
  end
  // ----------------------------------------
  // round robin scan and cascade master
  // ----------------------------------------
  always @(negedge sys_clk)
  begin
    if (!rst && !adc_valid)
    begin
      adc_valid <= 1'b1;
      adc_chan <= ch_q;
      adc_code <= rails[ch_q * 12 +: 12];
      adc_ovr <= over[ch_q];
      ch_q <= (ch_q == 5'h10) ? 5'h00 : ch_q + 5'h01;
    end
    else
    begin
      // idle lines toggle so stale data is never taken for a result
      adc_valid <= 1'b0;
      adc_chan <= ~adc_chan;
      adc_code <= ~adc_code;
      adc_ovr <= ~adc_ovr;
    end
    // master falls back to backup when main fails its check
    cascade_sel_valid <= cascade_report_valid_q;
    cascade_sel_backup <= cascade_report_valid_q ? !cascade_report_q[1] : ~cascade_sel_backup;
  end
endmodule

// ---- tb_supply_fault_detect_readback.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_supply_fault_detect_readback;
  logic sys_clk = 0, rst = 1, cmd_wr = 0, cmd_rd = 0, adc_valid, adc_ovr, nv_check_valid = 0;
  logic nv_boot_ok = 0, nv_fw_ok = 0, nv_main_ok = 0, nv_backup_ok = 0, cascade_sel_valid;
  logic cascade_sel_backup, cmd_ack_q, cmd_err_q, cascade_report_valid_q, cfg_ready_q, cfg_use_backup_q;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000, cmd_rdata_q, rd_s;
  logic [4:0] adc_chan;
  logic [11:0] adc_code;
  logic [16:0] seq_fault_ov_q, seq_fault_uv_q, logic_warn_ov_q, logic_warn_uv_q, over = 17'h00000;
  logic [3:0] cascade_report_q;
  logic [203:0] rails = 204'h0;
  logic err_s;
  logic [25:0] r;
  integer miscompares = 0, cmp_count = 0, i, p, r3;
  // {write, refused, code, data}: reads expect data, accepted writes are read back
  logic [25:0] rows [18] = '{{2'h0, 8'h2A, 16'h1000}, {2'h0, 8'h20, 16'h0000}, {2'h2, 8'h20, 16'h0013},
    {2'h2, 8'h22, 16'h00A5}, {2'h2, 8'h2A, 16'h0800}, {2'h2, 8'h40, 16'h1234}, {2'h2, 8'h42, 16'h2345},
    {2'h2, 8'h43, 16'h3456}, {2'h2, 8'h44, 16'h4567}, {2'h2, 8'hD0, 16'h5678}, {2'h2, 8'hD1, 16'h6789},
    {2'h2, 8'h20, 16'h0000}, {2'h2, 8'h22, 16'h0000}, {2'h2, 8'h2A, 16'h1000}, {2'h3, 8'h8B, 16'h0001},
    {2'h3, 8'hD3, 16'h0001}, {2'h3, 8'h55, 16'h0001}, {2'h3, 8'h00, 16'h0011}};
  sfdr_top dut_u (.*);
  sfdr_rail_model rail_u (.*);
  always #20 sys_clk = ~sys_clk;
  task automatic tally_and_finish;
    begin
      $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // strobe is a one-cycle pulse; the answer lands exactly one cycle later
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    begin
      cmd_wr = w;
      cmd_rd = !w;
      cmd_code = c;
      cmd_wdata = d;
      @(negedge sys_clk);
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      `CHK(cmd_ack_q, 1'b1)
      err_s = cmd_err_q;
      rd_s = cmd_rdata_q;
      @(negedge sys_clk);
    end
  endtask
  task automatic setup(input logic [15:0] ch, input logic [15:0] cfg, input logic [15:0] ovf, input logic [15:0] uvf);
    begin
      cmd(1'b1, 8'h00, ch);
      cmd(1'b1, 8'h40, ovf);
      cmd(1'b1, 8'h44, uvf);
      cmd(1'b1, 8'hD2, cfg);
    end
  endtask
  task automatic wait_f(input integer ch, input logic uv, input logic v);
    integer n;
    begin
      n = 0;
      cmp_count++;
      while ((uv ? seq_fault_uv_q[ch] : seq_fault_ov_q[ch]) !== v && n < 300)
      begin
        @(negedge sys_clk);
        n++;
      end
      if (n == 300)
      begin
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, !v, v);
        miscompares++;
        tally_and_finish;
      end
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    rails[4*12 +: 12] = 12'h600;
    rails[5*12 +: 12] = 12'h200;
    rails[6*12 +: 12] = 12'h500;
    rails[7*12 +: 12] = 12'h200;
    rails[8*12 +: 12] = 12'h100;
    rails[9*12 +: 12] = 12'h100;
    rails[10*12 +: 12] = 12'h400;
    over[8] = 1'b1;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    `CHK({cmd_ack_q, seq_fault_ov_q, logic_warn_ov_q, cfg_ready_q}, 36'h0)
    for (i = 0; i < 18; i++)
    begin
      r = rows[i];
      cmd(r[25], r[23:16], r[15:0]);
      `CHK(err_s, r[24])
      if (!r[24] && r[25])
        cmd(1'b0, r[23:16], 16'h0000);
      if (!r[24])
        `CHK(rd_s, r[15:0])
    end
    for (i = 0; i < 12; i++)
    begin
      p = (i < 6) ? 0 : 10;
      r3 = i % 6;
      cmd(1'b1, 8'h00, p[15:0]);
      cmd(1'b1, 8'hD2, {12'h000, r3[2:0], 1'b0});
      `CHK(err_s, (p == 0) ? (r3 == 3) : (r3 > 3))
    end
    nv_boot_ok = 1'b1;
    nv_fw_ok = 1'b1;
    nv_backup_ok = 1'b1;
    nv_check_valid = 1'b1;
    @(negedge sys_clk);
    nv_check_valid = 1'b0;
    `CHK({cascade_report_valid_q, cascade_report_q}, 5'h1D)
    repeat (3) @(negedge sys_clk);
    `CHK({cfg_ready_q, cfg_use_backup_q}, 2'h3)
    setup(16'h0005, 16'h0000, 16'h0000, 16'h0000);
    setup(16'h0004, 16'h8051, 16'h0500, 16'h0000);
    setup(16'h0007, 16'h8041, 16'h7FFF, 16'h0000);
    cmd(1'b1, 8'h42, 16'h0100);
    cmd(1'b1, 8'h43, 16'h0300);
    setup(16'h0008, 16'h8041, 16'h7FFF, 16'h0000);
    setup(16'h0009, 16'h8040, 16'h0000, 16'h0200);
    setup(16'h0006, 16'h8041, 16'h0400, 16'h0000);
    cmd(1'b1, 8'hD0, 16'h0064);
    repeat (36) @(negedge sys_clk);
    `CHK(seq_fault_ov_q[6], 1'b0)
    wait_f(6, 1'b0, 1'b1);
    wait_f(8, 1'b0, 1'b1);
    wait_f(9, 1'b1, 1'b1);
    `CHK(seq_fault_ov_q[4], 1'b0)
    `CHK({logic_warn_ov_q[7], logic_warn_uv_q[7]}, 2'h3)
    `CHK({seq_fault_ov_q[7], seq_fault_uv_q[7]}, 2'h0)
    rails[6*12 +: 12] = 12'h3D0;
    repeat (120) @(negedge sys_clk);
    `CHK(seq_fault_ov_q[6], 1'b1)
    rails[6*12 +: 12] = 12'h380;
    wait_f(6, 1'b0, 1'b0);
    cmd(1'b1, 8'h00, 16'h0008);
    cmd(1'b0, 8'h8B, 16'h0000);
    `CHK(rd_s, 16'h0100)
    cmd(1'b0, 8'hD3, 16'h0000);
    `CHK(rd_s, 16'h0075)
    cmd(1'b1, 8'h00, 16'h000A);
    cmd(1'b1, 8'h2A, 16'h0800);
    repeat (40) @(negedge sys_clk);
    cmd(1'b0, 8'h8B, 16'h0000);
    `CHK(rd_s, 16'h0200)
    cmd(1'b1, 8'h00, 16'h0006);
    cmd(1'b1, 8'h22, 16'h0010);
    repeat (40) @(negedge sys_clk);
    cmd(1'b0, 8'h8B, 16'h0000);
    `CHK(rd_s, 16'h0390)
    tally_and_finish;
  end
endmodule
